// [lldcir_core.sv]
`default_nettype none
module lldcir_core
	import lldcir_pkg::*;
#(
	parameter int unsigned STABLE_CYCLES = STABLE_CYC,
	parameter int unsigned LOCK_CYCLES = PLL_LOCK_CYC
) (
	input wire logic clk, // primary clock
	input wire logic arst_n, // async reset
	input wire logic chip_sel_n, // chip select
	input wire logic write_n, // write strobe
	input wire logic refresh_n, // refresh strobe
	input wire logic [ADDR_W-1:0] addr, // address / opcode
	input wire logic [BANK_W-1:0] bank, // bank select
	input wire logic [1:0] org, // organization strap
	input wire logic write_mask_in, // data mask, high drops beat
	input wire logic wr_beat, // write data beat strobe
	input wire logic clock_stopped, // clock was halted
	output logic [2:0] cmd_code, // decoded command
	output logic cmd_valid, // command accepted
	output logic [BANK_W-1:0] cmd_bank, // captured bank
	output logic [ADDR_W-1:0] cmd_addr, // masked location
	output logic [OPCODE_W-1:0] mode_reg, // mode register
	output logic [REF_ROW_W-1:0] refresh_row, // row refreshed
	output logic wr_commit, // beat written to array
	output logic [NBANKS-1:0] bank_busy, // per-bank busy
	output logic pll_locked, // lock timer done
	output logic init_done // ready for normal use
);
	logic cs_m_r, cs_r, we_m_r, we_r, rf_m_r, rf_r, msk_m_r, msk_r, wb_m_r, wb_r, cst_m_r, cst_r;
	logic [ADDR_W-1:0] a_m_r, a_r;
	logic [BANK_W-1:0] ba_m_r, ba_r;
	logic [1:0] org_m_r, org_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{cs_m_r, cs_r, we_m_r, we_r, rf_m_r, rf_r} <= 6'h3f;
			{msk_m_r, msk_r, wb_m_r, wb_r, cst_m_r, cst_r} <= 6'h00;
			a_m_r <= '0;
			a_r <= '0;
			ba_m_r <= '0;
			ba_r <= '0;
			org_m_r <= '0;
			org_r <= '0;
		end else begin
			{cs_m_r, we_m_r, rf_m_r, msk_m_r, wb_m_r, cst_m_r} <=
				{chip_sel_n, write_n, refresh_n, write_mask_in, wr_beat, clock_stopped};
			{cs_r, we_r, rf_r, msk_r, wb_r, cst_r} <= {cs_m_r, we_m_r, rf_m_r, msk_m_r, wb_m_r, cst_m_r};
			a_m_r <= addr;
			a_r <= a_m_r;
			ba_m_r <= bank;
			ba_r <= ba_m_r;
			org_m_r <= org;
			org_r <= org_m_r;
		end
	end
	logic [OPCODE_W-1:0] mode_r;
	logic [2:0] code_r;
	logic valid_r, commit_r;
	logic [BANK_W-1:0] cbank_r;
	logic [ADDR_W-1:0] caddr_r;
	logic [NBANKS-1:0] busy_r;
	logic [3:0] busy_cnt_r [NBANKS];
	logic in_burst_r;
	logic [1:0] burst_cnt_r;
	// command decode
	wire is_mode = !cs_r && !we_r && !rf_r;
	wire is_read = !cs_r && we_r && rf_r;
	wire is_write = !cs_r && !we_r && rf_r;
	wire is_ref = !cs_r && we_r && !rf_r;
	lldcir_cmd_t dec;
	assign dec = cs_r ? LLDCIR_NOP :
		is_mode ? LLDCIR_MODE :
		is_read ? LLDCIR_READ :
		is_write ? LLDCIR_WRITE :
		is_ref ? LLDCIR_REFRESH : LLDCIR_NOP;
	wire [1:0] blen_sel = mode_r[MODE_BURST_LSB +: 2];
	wire [4:0] aw = lldcir_addr_bits(org_r, blen_sel);
	wire [ADDR_W-1:0] amask = ADDR_W'((22'h1 << aw) - 22'h1);
	wire bank_free = !busy_r[ba_r];
	wire rw_ok = (dec == LLDCIR_READ || dec == LLDCIR_WRITE) && bank_free;
	wire ref_ok = (dec == LLDCIR_REFRESH) && bank_free;
	wire mode_ok = (dec == LLDCIR_MODE);
	wire accept = rw_ok || ref_ok || mode_ok;
	// nop only stops issuing, timers keep running
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= MODE_RESET;
			code_r <= LLDCIR_NOP;
			valid_r <= 1'b0;
			cbank_r <= '0;
			caddr_r <= '0;
		end else begin
			valid_r <= accept;
			code_r <= accept ? dec : LLDCIR_NOP;
			if (mode_ok) begin
				mode_r <= a_r[OPCODE_W-1:0];
			end
			if (rw_ok || ref_ok) begin
				cbank_r <= ba_r;
				caddr_r <= (dec == LLDCIR_REFRESH) ? '0 : (a_r & amask);
			end
		end
	end
	// bank row-cycle timers; a refresh holds its bank for a row cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NBANKS; i++) begin
				busy_cnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NBANKS; i++) begin
				if ((rw_ok || ref_ok) && ba_r == BANK_W'(i)) begin
					busy_cnt_r[i] <= 4'(TRC_CYC);
				end else if (busy_cnt_r[i] != 4'h0) begin
					busy_cnt_r[i] <= busy_cnt_r[i] - 4'h1;
				end
			end
		end
	end
	always_comb begin
		for (int i = 0; i < NBANKS; i++) begin
			busy_r[i] = busy_cnt_r[i] != 4'h0;
		end
	end
	// write beats: mask low commits, high drops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			in_burst_r <= 1'b0;
			burst_cnt_r <= '0;
			commit_r <= 1'b0;
		end else begin
			commit_r <= in_burst_r && wb_r && !msk_r;
			if (accept && dec == LLDCIR_WRITE) begin
				in_burst_r <= 1'b1;
				burst_cnt_r <= '0;
			end else if (in_burst_r && wb_r) begin
				burst_cnt_r <= burst_cnt_r + 2'h1;
				if (burst_cnt_r == ((blen_sel == BURST_LEN_2) ? 2'h0 : (blen_sel == BURST_LEN_4) ? 2'h1 : 2'h3)) begin
					in_burst_r <= 1'b0;
				end
			end
		end
	end
	lldcir_refresh_ctr u_ref (
		.clk(clk),
		.arst_n(arst_n),
		.refresh_go(ref_ok),
		.refresh_bank(ba_r),
		.refresh_row(refresh_row)
	);
	// power-up tracking, also PLL relock after a stopped clock
	lldcir_init_t st_r;
	logic [31:0] tmr_r;
	logic [1:0] mcnt_r;
	logic [NBANKS-1:0] refd_r;
	logic locked_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= LLDCIR_WAIT_STABLE;
			tmr_r <= '0;
			mcnt_r <= '0;
			refd_r <= '0;
			locked_r <= 1'b0;
		end else begin
			tmr_r <= tmr_r + 32'h1;
			case (st_r)
				LLDCIR_WAIT_STABLE: begin
					if (cs_r == 1'b0) begin
						tmr_r <= '0;
					end else if (tmr_r >= 32'(STABLE_CYCLES)) begin
						st_r <= LLDCIR_WAIT_MODE;
					end
				end
				LLDCIR_WAIT_MODE: begin
					if (mode_ok) begin
						mcnt_r <= (mcnt_r == 2'h3) ? mcnt_r : mcnt_r + 2'h1;
					end else if (mcnt_r >= 2'(CFG_CNT)) begin
						st_r <= LLDCIR_WAIT_REFRESH;
						tmr_r <= '0;
					end else begin
						mcnt_r <= '0;
					end
				end
				LLDCIR_WAIT_REFRESH: begin
					// timer restarts two cycles after the valid mode set
					if (ref_ok && tmr_r >= 32'(MODE_SET_RECOVERY_CYC - 2)) begin
						refd_r[ba_r] <= 1'b1;
					end
					if (&refd_r) begin
						st_r <= LLDCIR_WAIT_LOCK;
						tmr_r <= '0;
					end
				end
				LLDCIR_WAIT_LOCK: begin
					if (tmr_r >= 32'(LOCK_CYCLES + TRC_CYC)) begin
						st_r <= LLDCIR_READY;
						locked_r <= 1'b1;
					end
				end
				LLDCIR_READY: begin
					if (cst_r) begin
						locked_r <= 1'b0;
						st_r <= LLDCIR_WAIT_LOCK;
						tmr_r <= '0;
					end
				end
				default: st_r <= LLDCIR_WAIT_STABLE;
			endcase
		end
	end
	assign cmd_code = code_r;
	assign cmd_valid = valid_r;
	assign cmd_bank = cbank_r;
	assign cmd_addr = caddr_r;
	assign mode_reg = mode_r;
	assign wr_commit = commit_r;
	assign bank_busy = busy_r;
	assign pll_locked = locked_r;
	assign init_done = (st_r == LLDCIR_READY);
endmodule
`default_nettype wire

// [lldcir_core_props.sv]
`default_nettype none
module lldcir_core_props
	import lldcir_pkg::*;
#(
	parameter int unsigned STABLE_CYCLES = STABLE_CYC,
	parameter int unsigned LOCK_CYCLES = PLL_LOCK_CYC
) (
	input wire logic clk, // clock
	input wire logic arst_n, // reset
	input wire logic chip_sel_n, // select
	input wire logic write_n, // strobe
	input wire logic refresh_n, // strobe
	input wire logic [BANK_W-1:0] bank, // bank
	input wire logic [1:0] org, // strap
	input wire logic clock_stopped, // halt
	input wire logic [2:0] cmd_code, // command
	input wire logic cmd_valid, // pulse
	input wire logic [BANK_W-1:0] cmd_bank, // bank
	input wire logic [ADDR_W-1:0] cmd_addr, // address
	input wire logic [OPCODE_W-1:0] mode_reg, // mode
	input wire logic [NBANKS-1:0] bank_busy, // busy
	input wire logic pll_locked, // lock
	input wire logic init_done // ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire logic rd_pin = !chip_sel_n && write_n && refresh_n;
	wire logic wr_pin = !chip_sel_n && !write_n && refresh_n;
	wire logic rf_pin = !chip_sel_n && write_n && !refresh_n;
	wire logic md_pin = !chip_sel_n && !write_n && !refresh_n;
	wire logic [4:0] used_w = 5'h13 + {3'h0, org} - {3'h0, mode_reg[4:3]};
	sequence s_took(logic [2:0] c);
		cmd_valid && cmd_code == c;
	endsequence
	a_unselected_quiet: assert property (chip_sel_n |-> ##3 !cmd_valid) else $error("command after deselect");
	a_mode_taken: assert property (md_pin |-> ##3 s_took(3'h1)) else $error("mode set lost");
	a_read_decode: assert property (rd_pin |-> ##3 (!cmd_valid or (s_took(3'h2) and cmd_bank == $past(bank, 3))))
		else $error("read decode wrong");
	a_write_decode: assert property (wr_pin |-> ##3 (!cmd_valid or (s_took(3'h3) and cmd_bank == $past(bank, 3))))
		else $error("write decode wrong");
	a_refresh_decode: assert property (rf_pin |-> ##3 (!cmd_valid or (s_took(3'h4) and cmd_addr == '0)))
		else $error("refresh decode wrong");
	a_addr_width: assert property (s_took(3'h2) or s_took(3'h3) |-> (cmd_addr >> used_w) == '0)
		else $error("address wider than used");
	a_refresh_busy: assert property (s_took(3'h4) |-> bank_busy[cmd_bank]) else $error("refreshed bank idle");
	a_init_locked: assert property ($rose(init_done) |-> pll_locked) else $error("ready before lock");
	a_relock_drop: assert property ($rose(clock_stopped) |-> ##[1:4] !pll_locked) else $error("lock kept");
endmodule
bind lldcir_core lldcir_core_props #(.STABLE_CYCLES(STABLE_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) u_lldcir_core_props(
	.clk, .arst_n, .chip_sel_n, .write_n, .refresh_n, .bank, .org, .clock_stopped, .cmd_code, .cmd_valid,
	.cmd_bank, .cmd_addr, .mode_reg, .bank_busy, .pll_locked, .init_done);
`default_nettype wire

// [lldcir_ctrl_model.sv]
`default_nettype none
module lldcir_ctrl_model
	import lldcir_pkg::*;
#(
	parameter int unsigned STABLE = 20
) (
	input wire logic clk, // clock
	output logic chip_sel_n, // select
	output logic write_n, // strobe
	output logic refresh_n, // strobe
	output logic [ADDR_W-1:0] addr, // address
	output logic [BANK_W-1:0] bank, // bank
	output logic write_mask_in, // mask
	output logic wr_beat // beat
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{chip_sel_n, write_n, refresh_n, write_mask_in, wr_beat} = 5'h1e;
		addr = '0;
		bank = '0;
	end
	task automatic nop();
		@(negedge clk);
		chip_sel_n = 1'b1;
		addr = ~addr;
		bank = ~bank;
		wr_beat = 1'b0;
		write_mask_in = ~write_mask_in;
	endtask
	task automatic issue(input logic [2:0] p, input logic [ADDR_W-1:0] a, input logic [BANK_W-1:0] b);
		@(negedge clk);
		{chip_sel_n, write_n, refresh_n} = p;
		addr = a;
		bank = b;
	endtask
	task automatic beat(input logic m);
		@(negedge clk);
		wr_beat = 1'b1;
		write_mask_in = m;
	endtask
	task automatic init_seq(input logic [OPCODE_W-1:0] m);
		repeat (STABLE) nop();
		repeat (3) issue(3'h0, {3'h0, m}, 3'h0);
		repeat (MODE_SET_RECOVERY_CYC) nop();
		for (int i = 0; i < NBANKS; i++) issue(3'h2, 21'h0, i[2:0]);
		nop();
	endtask
endmodule
`default_nettype wire

// [lldcir_pkg.sv]
`default_nettype none
package lldcir_pkg;
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned ADDR_W = 21;
	localparam int unsigned BANK_W = 3;
	localparam int unsigned NBANKS = 8;
	localparam int unsigned OPCODE_W = 18;
	localparam int unsigned OPCODE_ZERO_LO = 10;
	localparam int unsigned OPCODE_ZERO_HI = 17;
	localparam int unsigned MODE_SET_RECOVERY_CYC = 6;
	localparam int unsigned TRC_NS = 20;
	localparam int unsigned TRC_CYC = (TRC_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned PLL_LOCK_US = 15;
	localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
	localparam int unsigned STABLE_US = 200;
	localparam int unsigned STABLE_CYC = STABLE_US * CLK_MHZ;
	localparam int unsigned REF_ROW_W = 13;
	localparam int unsigned CFG_CNT = 3;
	localparam logic [1:0] BURST_LEN_2 = 2'h0;
	localparam logic [1:0] BURST_LEN_4 = 2'h1;
	localparam logic [1:0] BURST_LEN_8 = 2'h2;
	localparam logic [1:0] ORG_X36 = 2'h0;
	localparam logic [1:0] ORG_X18 = 2'h1;
	localparam logic [1:0] ORG_X9 = 2'h2;
	localparam int unsigned MODE_BURST_LSB = 3;
	localparam logic [OPCODE_W-1:0] MODE_RESET = 18'h00000;
	typedef enum logic [2:0] {
		LLDCIR_NOP,
		LLDCIR_MODE,
		LLDCIR_READ,
		LLDCIR_WRITE,
		LLDCIR_REFRESH
	} lldcir_cmd_t;
	typedef enum {
		LLDCIR_WAIT_STABLE,
		LLDCIR_WAIT_MODE,
		LLDCIR_WAIT_REFRESH,
		LLDCIR_WAIT_LOCK,
		LLDCIR_READY
	} lldcir_init_t;
	function automatic logic [4:0] lldcir_addr_bits(input logic [1:0] org, input logic [1:0] blen);
		logic [4:0] w;
		w = 5'd19 + {3'h0, org} - ((blen == BURST_LEN_2) ? 5'd0 : ((blen == BURST_LEN_4) ? 5'd1 : 5'd2));
		return w;
	endfunction
endpackage
`default_nettype wire

// [lldcir_refresh_ctr.sv]
`default_nettype none
module lldcir_refresh_ctr
	import lldcir_pkg::*;
(
	input wire logic clk, // clock
	input wire logic arst_n, // async reset
	input wire logic refresh_go, // refresh strobe
	input wire logic [BANK_W-1:0] refresh_bank, // bank refreshed
	output logic [REF_ROW_W-1:0] refresh_row // row of that bank
);
	logic [REF_ROW_W-1:0] row_r [NBANKS];
	logic [REF_ROW_W-1:0] row_out_r;
	assign refresh_row = row_out_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NBANKS; i++) begin
				row_r[i] <= '0;
			end
			row_out_r <= '0;
		end else if (refresh_go) begin
			row_out_r <= row_r[refresh_bank];
			row_r[refresh_bank] <= row_r[refresh_bank] + 1'b1;
		end
	end
endmodule
`default_nettype wire

// [lldram_command_init_refresh_bench.sv]
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch at %0t got %0h exp %0h", $time, g, e); end end
module lldram_command_init_refresh_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import lldcir_pkg::*;
	logic clk, arst_n, clock_stopped, cmd_valid, wr_commit, pll_locked, init_done;
	logic [1:0] org;
	logic [2:0] cmd_code;
	logic [BANK_W-1:0] cmd_bank;
	logic [ADDR_W-1:0] cmd_addr;
	logic [OPCODE_W-1:0] mode_reg;
	logic [NBANKS-1:0] bank_busy;
	logic [REF_ROW_W-1:0] refresh_row;
	wire logic chip_sel_n, write_n, refresh_n, write_mask_in, wr_beat;
	wire logic [ADDR_W-1:0] addr;
	wire logic [BANK_W-1:0] bank;
	int n_errors = 0;
	int total_checks = 0;
	lldcir_ctrl_model u_lldcir_ctrl_model(.clk, .chip_sel_n, .write_n, .refresh_n, .addr, .bank, .write_mask_in,
		.wr_beat);
	lldcir_core #(.STABLE_CYCLES(20), .LOCK_CYCLES(10)) u_lldcir_core(.clk, .arst_n, .chip_sel_n, .write_n,
		.refresh_n, .addr, .bank, .org, .write_mask_in, .wr_beat, .clock_stopped, .cmd_code, .cmd_valid, .cmd_bank,
		.cmd_addr, .mode_reg, .refresh_row, .wr_commit, .bank_busy, .pll_locked, .init_done);
	task automatic close_out();
		if (n_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cmd(input logic [2:0] p, input logic [ADDR_W-1:0] a, input logic [BANK_W-1:0] b);
		u_lldcir_ctrl_model.issue(p, a, b);
		u_lldcir_ctrl_model.nop();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic count_hits(input int span, output int n);
		n = 0;
		repeat (span) begin
			@(posedge clk);
			#1;
			if (wr_commit === 1'b1 || (cmd_valid === 1'b1 && span == 5)) n++;
		end
	endtask
	task automatic t_init();
		u_lldcir_ctrl_model.init_seq(18'h00008);
		for (int i = 0; i < 200 && init_done !== 1'b1; i++) @(posedge clk);
		`CHK(init_done, 1'b1)
		`CHK(pll_locked, 1'b1)
		cmd(3'h0, 21'h1c0008, 3'h0);
		`CHK(cmd_code, 3'h1)
		`CHK(mode_reg, 18'h00008)
		repeat (MODE_SET_RECOVERY_CYC) u_lldcir_ctrl_model.nop();
	endtask
	task automatic t_rw();
		int n;
		cmd(3'h3, 21'h1fffff, 3'h1);
		`CHK({cmd_valid, cmd_code, cmd_bank, cmd_addr}, {1'b1, 3'h2, 3'h1, 21'h03ffff})
		@(negedge clk);
		org = ORG_X9;
		repeat (4) u_lldcir_ctrl_model.nop();
		cmd(3'h1, 21'h1fffff, 3'h2);
		`CHK({cmd_valid, cmd_code, cmd_bank, cmd_addr}, {1'b1, 3'h3, 3'h2, 21'h0fffff})
		u_lldcir_ctrl_model.beat(1'b1);
		u_lldcir_ctrl_model.nop();
		count_hits(6, n);
		`CHK(n, 0)
		u_lldcir_ctrl_model.beat(1'b0);
		u_lldcir_ctrl_model.nop();
		count_hits(6, n);
		`CHK(n, 1)
	endtask
	task automatic t_unselect_refresh();
		int n;
		u_lldcir_ctrl_model.issue(3'h4, 21'h0, 3'h3);
		u_lldcir_ctrl_model.nop();
		count_hits(5, n);
		`CHK(n, 0)
		cmd(3'h2, 21'h12345, 3'h5);
		`CHK({cmd_valid, cmd_code, cmd_bank, cmd_addr}, {1'b1, 3'h4, 3'h5, 21'h0})
		`CHK(bank_busy[5], 1'b1)
		`CHK(refresh_row, 13'h0001)
	endtask
	task automatic t_relock();
		@(negedge clk);
		clock_stopped = 1'b1;
		@(negedge clk);
		clock_stopped = 1'b0;
		for (int i = 0; i < 5 && pll_locked !== 1'b0; i++) @(posedge clk);
		`CHK(pll_locked, 1'b0)
		for (int i = 0; i < 40 && pll_locked !== 1'b1; i++) @(posedge clk);
		`CHK(pll_locked, 1'b1)
		cmd(3'h3, 21'h000010, 3'h6);
		`CHK({cmd_valid, cmd_code, cmd_bank}, {1'b1, 3'h2, 3'h6})
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#(2000 * 20);
		n_errors++;
		close_out();
	end
	initial begin
		arst_n = 1'b0;
		org = ORG_X36;
		clock_stopped = 1'b0;
		repeat (20) @(negedge clk);
		arst_n = 1'b1;
		t_init();
		t_rw();
		t_unselect_refresh();
		t_relock();
		close_out();
	end
endmodule
`default_nettype wire
